// *** design/switch_input_config_regs.sv ***

`include "switch_input_consts.svh"

module switch_input_config_regs #(
	parameter int NUM_IN = `NUM_INPUTS   // number of switch inputs
) (
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic                       ce,
	input  wire logic                       wrEn,
	input  wire logic                       rdEn,
	input  wire logic [7:0]                 addr,
	input  wire logic [23:0]                wrData,
	input  wire logic                       trigger,
	input  wire logic                       pollEnable,
	input  wire logic                       pollTick,
	output logic      [23:0]                rdData,
	output logic                            rdValid,
	output logic      [23:0]                channelActive,
	output logic      [9:0]                 sinkSelect,
	output logic      [11:0][2:0]           wetLevel,
	output logic                            sampleStrobe,
	output logic      [4:0]                 sampleChan
);
	import switch_input_pkg::*;

	// ****************************************
	// state and decoders
	// ****************************************
	state_t                 r;          // registered state
	state_t                 n;          // next state
	wet_level_t             decoded [12];  // per-input decoded level

	// one decoder per wetting input; pairs read the same field
	generate
		for (genvar g = 0; g < `NUM_WET_INPUTS; g++) begin : gen_wet
			localparam int F = fieldOf(g);
			wetting_decode u_dec (
				.code  (r.wcCfg[F*`WET_CODE_W +: `WET_CODE_W]),
				.level (decoded[g])
			);
		end
	endgenerate

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic   found;
		logic [4:0] nextCh;
		int     j;
		found  = 1'b0;
		nextCh = r.chan;
		j      = 0;
		n      = r;
		n.rdValid      = 1'b0;
		n.sampleStrobe = 1'b0;
		// register writes; reconfiguring while running is the host's problem
		if (wrEn) begin
			unique case (addr)
				`ADDR_INPUT_CHANNEL_ENABLE:      n.inEn   = wrData;
				`ADDR_CURRENT_DIRECTION_SELECT:  n.dirSel = wrData[9:0];
				`ADDR_WETTING_CURRENT_CFG_LOW:   n.wcCfg  = wrData;
				default: ;  // unmapped writes dropped
			endcase
		end
		// readback, reserved direction bits read zero
		if (rdEn) begin
			n.rdValid = 1'b1;
			unique case (addr)
				`ADDR_INPUT_CHANNEL_ENABLE:      n.rdData = r.inEn;
				`ADDR_CURRENT_DIRECTION_SELECT:  n.rdData = {14'h0000, r.dirSel};
				`ADDR_WETTING_CURRENT_CFG_LOW:   n.rdData = r.wcCfg;
				default:                         n.rdData = 24'h00_0000;
			endcase
		end
		// mode follows run and poll enable
		if (!trigger) begin
			n.mode = MODE_IDLE;
		end else if (pollEnable) begin
			n.mode = MODE_POLL;
		end else begin
			n.mode = MODE_CONT;
		end
		// search for the next enabled channel after the current one
		// full scan every cycle costs a wide priority chain,
		// but a tick never has to wait for the pointer to walk
		for (int i = 1; i <= NUM_IN; i++) begin
			j = int'(r.chan) + i;
			if (j >= NUM_IN) begin
				j = j - NUM_IN;
			end
			if (!found && r.inEn[j]) begin
				found  = 1'b1;
				nextCh = 5'(j);
			end
		end
		// drive the per-mode activity
		unique case (r.mode)
			MODE_IDLE: begin
				n.channelActive = 24'h00_0000;
			end
			MODE_CONT: begin
				n.channelActive = r.inEn;
			end
			MODE_POLL: begin
				n.channelActive = 24'h00_0000;
				// no enabled channel means no sample at all
				if (pollTick && found) begin
					n.chan          = nextCh;
					n.sampleStrobe  = 1'b1;
					n.sampleChan    = nextCh;
					n.channelActive = 24'(1) << nextCh;
				end
			end
		endcase
		// copies below lag their registers by one cycle on purpose
		n.sinkSelect = r.dirSel;
		for (int k = 0; k < `NUM_WET_INPUTS; k++) begin
			n.wetLevel[k] = decoded[k];
		end
	end

	// ****************************************
	// state register
	// ****************************************
	// reset wins over the clock enable; a low enable holds everything
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			r        <= '0;
			r.mode   <= MODE_IDLE;
			r.inEn   <= `RST_INPUT_ENABLE;
			r.dirSel <= `RST_DIRECTION;
			r.wcCfg  <= `RST_WETTING_CFG;
		end else if (ce) begin
			r <= n;
		end
	end

	// outputs are straight copies of flops, no gates behind them
	assign rdData        = r.rdData;
	assign rdValid       = r.rdValid;
	assign channelActive = r.channelActive;
	assign sinkSelect    = r.sinkSelect;
	assign wetLevel      = r.wetLevel;
	assign sampleStrobe  = r.sampleStrobe;
	assign sampleChan    = r.sampleChan;

	// ****************************************
	// checks
	// ****************************************
	// all checks sleep while reset is low, since reset beats enable
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_enable_write: assert property (
		ce && wrEn && addr == `ADDR_INPUT_CHANNEL_ENABLE
		|=> r.inEn == $past(wrData)) else $error("enable write lost");
	chk_skip_disabled: assert property (
		sampleStrobe |-> r.inEn[sampleChan] && channelActive[sampleChan])
		else $error("disabled channel sampled");
	chk_dir_source: assert property (
		ce && wrEn && addr == `ADDR_CURRENT_DIRECTION_SELECT && !wrData[0]
		##1 ce |=> !sinkSelect[0]) else $error("source not selected");
	chk_dir_sink: assert property (
		ce && wrEn && addr == `ADDR_CURRENT_DIRECTION_SELECT && wrData[9]
		##1 ce |=> sinkSelect[9]) else $error("sink not selected");
	chk_wet_low: assert property (
		$past(ce) && $past(r.wcCfg[5:3]) == 3'h2 |-> wetLevel[2] == WET_2MA)
		else $error("2mA code misdecoded");
	chk_wet_mid: assert property (
		$past(ce) && $past(r.wcCfg[8:6]) == 3'h4 |-> wetLevel[4] == WET_10MA)
		else $error("10mA code misdecoded");
	chk_wet_top: assert property (
		$past(ce) && $past(r.wcCfg[23:21]) >= 3'h5 |-> wetLevel[11] == WET_15MA)
		else $error("15mA code misdecoded");
	chk_pair_equal: assert property (
		wetLevel[0] == wetLevel[1] && wetLevel[6] == wetLevel[7]
		&& wetLevel[8] == wetLevel[9]) else $error("pair levels differ");
	chk_cont_mode: assert property (
		$past(ce) && $past(r.mode) == MODE_CONT |-> channelActive == $past(r.inEn))
		else $error("continuous mode mismatch");
	chk_idle_quiet: assert property (
		ce && !trigger ##1 ce |=> channelActive == 24'h00_0000 && !sampleStrobe)
		else $error("activity while stopped");
	// strobe cycle shows exactly one active channel
	chk_poll_onehot: assert property (
		sampleStrobe |-> $onehot(channelActive))
		else $error("poll activity not one-hot");
	// a tick with any enabled input must give a sample
	chk_poll_advance: assert property (
		ce && r.mode == MODE_POLL && pollTick && r.inEn != 24'h00_0000
		|=> sampleStrobe) else $error("poll tick lost");
	// no sampling outside polling mode
	chk_run_no_strobe: assert property (
		ce && r.mode != MODE_POLL |=> !sampleStrobe)
		else $error("sample outside polling");
	// reserved direction bits never leak into readback
	chk_reserved_zero: assert property (
		ce && rdEn && addr == `ADDR_CURRENT_DIRECTION_SELECT
		|=> rdData[23:10] == 14'h0000) else $error("reserved bits read nonzero");
	// enable low freezes the whole bank, outputs included
	chk_ce_freeze: assert property (
		!ce |=> $stable(r)) else $error("state moved while frozen");

	cov_poll_sample: cover property (sampleStrobe && sampleChan == 5'h17);
	cov_cont_run:    cover property (r.mode == MODE_CONT && channelActive != 24'h00_0000);
	cov_top_code:    cover property (wetLevel[5] == WET_15MA);
	cov_ce_freeze:   cover property (!ce ##1 ce);
	cov_sink_all:    cover property (sinkSelect == 10'h3ff);
endmodule : switch_input_config_regs

// *** design/switch_input_consts.svh ***
`ifndef SWITCH_INPUT_CONSTS_SVH
`define SWITCH_INPUT_CONSTS_SVH

// ****************************************
// register offsets
// ****************************************
`define ADDR_INPUT_CHANNEL_ENABLE       8'h1B
`define ADDR_CURRENT_DIRECTION_SELECT  8'h1C
`define ADDR_WETTING_CURRENT_CFG_LOW   8'h1D

// ****************************************
// field positions and widths
// ****************************************
`define NUM_INPUTS       24
`define NUM_DIR_INPUTS   10
`define NUM_WET_INPUTS   12
`define WET_CODE_W       3

// ****************************************
// reset values
// ****************************************
`define RST_INPUT_ENABLE   24'h00_0000
`define RST_DIRECTION      10'h000
`define RST_WETTING_CFG    24'h00_0000

`endif

// *** design/switch_input_pkg.sv ***
package switch_input_pkg;

	// ****************************************
	// operating modes of the front end
	// ****************************************
	typedef enum logic [2:0] {
		MODE_IDLE = 3'b001,  // stopped, no current applied
		MODE_CONT = 3'b010,  // continuous wetting current
		MODE_POLL = 3'b100   // periodic sampling
	} mode_t;

	// ****************************************
	// decoded wetting current level
	// ****************************************
	typedef enum logic [2:0] {
		WET_OFF  = 3'h0,
		WET_1MA  = 3'h1,
		WET_2MA  = 3'h2,
		WET_5MA  = 3'h3,
		WET_10MA = 3'h4,
		WET_15MA = 3'h5
	} wet_level_t;

	// ****************************************
	// complete state of the register bank
	// ****************************************
	typedef struct packed {
		mode_t                   mode;
		logic [23:0]             inEn;
		logic [9:0]              dirSel;
		logic [23:0]             wcCfg;
		logic [4:0]              chan;
		logic [23:0]             rdData;
		logic                    rdValid;
		logic [23:0]             channelActive;
		logic [9:0]              sinkSelect;
		logic [11:0][2:0]        wetLevel;
		logic                    sampleStrobe;
		logic [4:0]              sampleChan;
	} state_t;

	// which 3-bit wetting field governs a given input
	function automatic int fieldOf(input int inputNum);
		case (inputNum)
			0, 1:    fieldOf = 0;
			2, 3:    fieldOf = 1;
			4:       fieldOf = 2;
			5:       fieldOf = 3;
			6, 7:    fieldOf = 4;
			8, 9:    fieldOf = 5;
			10:      fieldOf = 6;
			default: fieldOf = 7;
		endcase
	endfunction : fieldOf

endpackage : switch_input_pkg

// *** design/wetting_decode.sv ***
// ****************************************
// wetting code to current level
// ****************************************
module wetting_decode (
	input  wire logic [2:0]                 code,
	output switch_input_pkg::wet_level_t    level
);
	import switch_input_pkg::*;

	// codes 5 to 7 all collapse onto the top setting
	always_comb begin
		unique case (code)
			3'h0:    level = WET_OFF;
			3'h1:    level = WET_1MA;
			3'h2:    level = WET_2MA;
			3'h3:    level = WET_5MA;
			3'h4:    level = WET_10MA;
			default: level = WET_15MA;
		endcase
	end
endmodule : wetting_decode

// *** test/host_model.sv ***
// ****************************************
// host side of the register bank
// ****************************************
module host_model (
	input  wire logic        clk,
	input  wire logic        rdValid,
	input  wire logic [23:0] rdData,
	output logic             ce,
	output logic             wrEn,
	output logic             rdEn,
	output logic [7:0]       addr,
	output logic [23:0]      wrData,
	output logic             trigger,
	output logic             pollEnable,
	output logic             pollTick
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle bus at time zero, clock enable held high
	initial begin
		{wrEn, rdEn, addr, wrData, trigger, pollEnable, pollTick} = '0;
		ce = 1'b1;
	end

	// one write, strobe up for exactly one taking edge
	task automatic wr(input logic [7:0] a, input logic [23:0] d);
		@(posedge clk);
		wrEn <= 1'b1;
		addr <= a;
		wrData <= d;
		@(posedge clk);
		wrEn <= 1'b0;
	endtask : wr

	// one read, answer sampled once the taking edge has landed
	task automatic rd(input logic [7:0] a, output logic [23:0] d, output logic v);
		@(posedge clk);
		rdEn <= 1'b1;
		addr <= a;
		@(posedge clk);
		rdEn <= 1'b0;
		#1;
		v = rdValid;
		d = rdData;
	endtask : rd

	// one poll step pulse
	task automatic tick();
		@(posedge clk);
		pollTick <= 1'b1;
		@(posedge clk);
		pollTick <= 1'b0;
	endtask : tick

	// clock enable level, changed just after an edge
	task automatic setCe(input logic c);
		@(posedge clk);
		ce <= c;
	endtask : setCe

	// mode change, then let mode register and outputs settle
	task automatic run(input logic t, input logic p);
		@(posedge clk);
		trigger <= t;
		pollEnable <= p;
		repeat (3) @(posedge clk);
	endtask : run
endmodule : host_model

// *** test/switch_input_config_regs_tb.sv ***
`include "switch_input_consts.svh"

module switch_input_config_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************
	// wires between host, bank and checks
	// ****************************************
	logic             clk = 1'b0;
	logic             rstN = 1'b0;
	logic             ce, wrEn, rdEn, trigger, pollEnable, pollTick;
	logic             rdValid, sampleStrobe;
	logic [7:0]       addr;
	logic [23:0]      wrData, rdData, channelActive;
	logic [9:0]       sinkSelect;
	logic [11:0][2:0] wetLevel;
	logic [4:0]       sampleChan;
	int               errCount = 0;
	int               totalChecks = 0;

	always #20 clk = ~clk;

	switch_input_config_regs u_switch_input_config_regs (.clk(clk), .rst_n(rstN), .ce(ce),
		.wrEn(wrEn), .rdEn(rdEn), .addr(addr), .wrData(wrData), .trigger(trigger),
		.pollEnable(pollEnable), .pollTick(pollTick), .rdData(rdData), .rdValid(rdValid),
		.channelActive(channelActive), .sinkSelect(sinkSelect), .wetLevel(wetLevel),
		.sampleStrobe(sampleStrobe), .sampleChan(sampleChan));

	host_model u_host_model (.clk(clk), .rdValid(rdValid), .rdData(rdData), .ce(ce),
		.wrEn(wrEn), .rdEn(rdEn), .addr(addr), .wrData(wrData), .trigger(trigger),
		.pollEnable(pollEnable), .pollTick(pollTick));

	// ****************************************
	// checking helpers
	// ****************************************
	task automatic results();
		$display("checks %0d errors %0d", totalChecks, errCount);
		if (errCount == 0 && totalChecks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : results

	task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
		totalChecks++;
		if (g !== e) begin
			errCount++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// read must answer with a valid pulse and the expected word
	task automatic rdChk(input logic [7:0] a, input logic [23:0] e);
		logic [23:0] d;
		logic        v;
		u_host_model.rd(a, d, v);
		chk("rdValid", 36'h1, {35'h0, v});
		chk("rdData", {12'h0, e}, {12'h0, d});
	endtask : rdChk

	// one tick, bounded wait for the sample, then a one-hot single pulse
	task automatic pollChk(input logic [4:0] ch);
		int i;
		u_host_model.tick();
		for (i = 0; i < 4; i++) begin
			#1;
			if (sampleStrobe === 1'b1) break;
			@(posedge clk);
		end
		if (i == 4) begin
			errCount++;
			results();
		end else begin
			chk("sampleChan", {31'h0, ch}, {31'h0, sampleChan});
			chk("channelActive", {12'h0, 24'h1 << ch}, {12'h0, channelActive});
			@(posedge clk);
			#1;
			chk("strobeEnd", 36'h0, {35'h0, sampleStrobe});
		end
	endtask : pollChk

	// ****************************************
	// main sequence, host stopped while configuring
	// ****************************************
	initial begin
		repeat (8) @(posedge clk);
		rstN <= 1'b1;
		@(posedge clk);
		rdChk(`ADDR_INPUT_CHANNEL_ENABLE, 24'h0);
		rdChk(`ADDR_CURRENT_DIRECTION_SELECT, 24'h0);
		rdChk(`ADDR_WETTING_CURRENT_CFG_LOW, 24'h0);
		u_host_model.wr(`ADDR_INPUT_CHANNEL_ENABLE, 24'h80_0021);
		rdChk(`ADDR_INPUT_CHANNEL_ENABLE, 24'h80_0021);
		u_host_model.wr(`ADDR_CURRENT_DIRECTION_SELECT, 24'hff_ffff);
		rdChk(`ADDR_CURRENT_DIRECTION_SELECT, 24'h00_03ff);
		chk("sinkSelect", 36'h3ff, {26'h0, sinkSelect});
		u_host_model.wr(`ADDR_CURRENT_DIRECTION_SELECT, 24'h00_0155);
		repeat (2) @(posedge clk);
		#1;
		chk("sinkSelect", 36'h155, {26'h0, sinkSelect});
		// bit 0 cleared and bit 9 set: both directions on the end pins
		u_host_model.wr(`ADDR_CURRENT_DIRECTION_SELECT, 24'h00_02aa);
		repeat (2) @(posedge clk);
		#1;
		chk("sinkSelect", 36'h2aa, {26'h0, sinkSelect});
		// every code 0..7 in one word: fields low to high carry 0..7
		u_host_model.wr(`ADDR_WETTING_CURRENT_CFG_LOW, 24'hfa_c688);
		rdChk(`ADDR_WETTING_CURRENT_CFG_LOW, 24'hfa_c688);
		chk("wetLevel", 36'hb_6d91_a240, wetLevel);
		// shuffled codes: 2mA on pair 2/3, 10mA on input 4, 15mA on input 5
		u_host_model.wr(`ADDR_WETTING_CURRENT_CFG_LOW, 24'h07_dd13);
		rdChk(`ADDR_WETTING_CURRENT_CFG_LOW, 24'h07_dd13);
		chk("wetLevel", 36'h0_6db6_c49b, wetLevel);
		u_host_model.wr(8'h20, 24'h12_3456);
		rdChk(8'h20, 24'h0);
		u_host_model.run(1'b1, 1'b0);
		#1;
		chk("contActive", 36'h80_0021, {12'h0, channelActive});
		u_host_model.run(1'b1, 1'b1);
		#1;
		chk("pollQuiet", 36'h0, {12'h0, channelActive});
		pollChk(5'd5);
		pollChk(5'd23);
		pollChk(5'd0);
		u_host_model.run(1'b0, 1'b0);
		#1;
		chk("idleActive", 36'h0, {12'h0, channelActive});
		// low clock enable: the write is not taken, the bank holds
		u_host_model.setCe(1'b0);
		u_host_model.wr(`ADDR_INPUT_CHANNEL_ENABLE, 24'h00_0001);
		u_host_model.setCe(1'b1);
		rdChk(`ADDR_INPUT_CHANNEL_ENABLE, 24'h80_0021);
		// reset while stopped brings every host register back to zero
		@(posedge clk);
		rstN <= 1'b0;
		repeat (2) @(posedge clk);
		rstN <= 1'b1;
		@(posedge clk);
		#1;
		chk("rstSink", 36'h0, {26'h0, sinkSelect});
		chk("rstWet", 36'h0, wetLevel);
		rdChk(`ADDR_INPUT_CHANNEL_ENABLE, 24'h0);
		rdChk(`ADDR_WETTING_CURRENT_CFG_LOW, 24'h0);
		results();
	end
endmodule : switch_input_config_regs_tb
